// ===== design/uep_consts.svh
// constants for the usb endpoint control block: offsets, fields, reset values, timing
// assumes a 25 MHz clock and a plain address/strobe register port
`ifndef UEP_CONSTS_SVH
`define UEP_CONSTS_SVH
`define UEP_CLK_HZ 25000000
`define UEP_SUSPEND_US 3000
`define UEP_SUSPEND_CYC ((`UEP_SUSPEND_US * (`UEP_CLK_HZ / 1000000)))
`define UEP_RESUME_WAIT_US 5000
`define UEP_RESUME_WAIT_CYC ((`UEP_RESUME_WAIT_US * (`UEP_CLK_HZ / 1000000)))
`define UEP_RESUME_DRIVE_US 2000
`define UEP_RESUME_DRIVE_CYC ((`UEP_RESUME_DRIVE_US * (`UEP_CLK_HZ / 1000000)))
`define UEP_BUS_RESET_NS 2500
`define UEP_BUS_RESET_CYC (((`UEP_BUS_RESET_NS * (`UEP_CLK_HZ / 1000000)) + 999) / 1000)
`define UEP_REG_CTRL 4'h0
`define UEP_REG_STATUS 4'h1
`define UEP_REG_ADDR 4'h2
`define UEP_REG_EPSEL 4'h3
`define UEP_REG_EPCFG 4'h4
`define UEP_REG_EPCMD 4'h5
`define UEP_REG_EPFLAG 4'h6
`define UEP_CTRL_ENABLE 0
`define UEP_CTRL_DETACH 1
`define UEP_CTRL_LOWSPEED 2
`define UEP_CTRL_RESUME 3
`define UEP_CTRL_RESET 8'h02
`define UEP_ST_SUSPEND 0
`define UEP_ST_WAKE 1
`define UEP_ST_UPRESUME 2
`define UEP_ST_EORESUME 3
`define UEP_ST_BUSRESET 4
`define UEP_ADDR_ENABLE 7
`define UEP_DEFAULT_ADDR 7'h00
`define UEP_CFG_ENABLE 0
`define UEP_CFG_SIZE_LSB 1
`define UEP_CFG_BANK 4
`define UEP_CFG_RESERVE 5
`define UEP_CFG_CONTROL 6
`define UEP_CMD_STALL_SET 0
`define UEP_CMD_STALL_CLR 1
`define UEP_CMD_RESET_TOGGLE 2
`define UEP_FL_SETUP 0
`define UEP_FL_OUT 1
`define UEP_FL_STALLED 2
`define UEP_FL_INREADY 3
`define UEP_FL_FIFOCTL 4
`define UEP_FL_RWOK 5
`define UEP_FL_CONFIGURATION_VALID_FLAG 6
`define UEP_FL_TOGGLE 7
`endif

// ===== design/uep_ctrl.sv
// usb device endpoint control: selection, activation, address, suspend/resume, stall
// assumes a packet decoder ahead of it and line state sampled synchronously to clk
`default_nettype none
`include "uep_consts.svh"
module uep_ctrl
  import uep_pkg::*;
#(
  parameter int NUM_EP = 7,
  parameter int MEM_BYTES = 832,
  parameter int SUSPEND_CYC = `UEP_SUSPEND_CYC,
  parameter int RESUME_WAIT_CYC = `UEP_RESUME_WAIT_CYC,
  parameter int RESUME_DRIVE_CYC = `UEP_RESUME_DRIVE_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic line_idle,
  input wire logic line_se0,
  input wire logic line_eor,
  input wire uep_pkt_s pkt,
  output uep_ans_s ans,
  output logic resume_drive,
  output logic pullup_dp,
  output logic pullup_dm,
  output logic full_speed
);
  localparam int BUS_RESET_CYC = `UEP_BUS_RESET_CYC;
  // refuse sizes that the 3-bit select and the fixed-width timers cannot reach
  if (NUM_EP < 1 || NUM_EP > 8) begin : g_bad_ep
    $error("uep_ctrl: NUM_EP must be 1..8");
  end
  if (MEM_BYTES < 8) begin : g_bad_mem
    $error("uep_ctrl: MEM_BYTES must hold one 8-byte endpoint");
  end
  if (SUSPEND_CYC < 1 || RESUME_WAIT_CYC < 1 || RESUME_DRIVE_CYC < 1) begin : g_bad_time
    $error("uep_ctrl: timing counts must be positive");
  end
  if (SUSPEND_CYC > 16777215 || RESUME_WAIT_CYC > 16777215
      || RESUME_DRIVE_CYC > 16777215) begin : g_big_time
    $error("uep_ctrl: timing counts must fit the 24-bit timers");
  end
  if (BUS_RESET_CYC < 1 || BUS_RESET_CYC > 255) begin : g_bad_se0
    $error("uep_ctrl: bus reset count must fit the 8-bit counter");
  end

  logic [7:0] ctrl_reg;
  logic [4:0] status_reg;
  logic [6:0] dev_addr_reg;
  logic addr_en_reg;
  logic [2:0] ep_sel_reg;
  logic [7:0] ep_cfg_reg [NUM_EP];
  logic [7:0] ep_flag_reg [NUM_EP];
  logic [NUM_EP-1:0] stall_rq_reg;
  logic [7:0] rdata_next;
  logic [23:0] idle_cnt_reg;
  logic [7:0] se0_cnt_reg;
  logic [23:0] rs_cnt_reg;
  uep_rs_e rs_state_reg;
  logic bus_reset;
  logic ctl_off;
  logic ans_match;
  logic wr_ctrl, wr_status, wr_addr, wr_sel, wr_cfg, wr_cmd, wr_flag;

  assign ctl_off = ~ctrl_reg[`UEP_CTRL_ENABLE];
  assign wr_ctrl = reg_wr && reg_addr == `UEP_REG_CTRL;
  assign wr_status = reg_wr && reg_addr == `UEP_REG_STATUS;
  assign wr_addr = reg_wr && reg_addr == `UEP_REG_ADDR;
  assign wr_sel = reg_wr && reg_addr == `UEP_REG_EPSEL;
  assign wr_cfg = reg_wr && reg_addr == `UEP_REG_EPCFG;
  assign wr_cmd = reg_wr && reg_addr == `UEP_REG_EPCMD;
  assign wr_flag = reg_wr && reg_addr == `UEP_REG_EPFLAG;
  assign bus_reset = line_se0 && se0_cnt_reg == 8'(BUS_RESET_CYC - 1);

  // bus reset detection; counter saturates so reset fires once per SE0
  always_ff @(posedge clk) begin
    if (!reset_n || !line_se0) begin
      se0_cnt_reg <= 8'h00;
    end else if (se0_cnt_reg != 8'(BUS_RESET_CYC)) begin
      se0_cnt_reg <= se0_cnt_reg + 8'h01;
    end
  end

  // line inactivity timer, shared by suspend and remote resume
  always_ff @(posedge clk) begin
    if (!reset_n || !line_idle || ctl_off) begin
      idle_cnt_reg <= 24'h000000;
    end else if (idle_cnt_reg != 24'hffffff) begin
      idle_cnt_reg <= idle_cnt_reg + 24'h000001;
    end
  end

  // general control: enable, detach, low speed, remote resume request
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_reg <= `UEP_CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= {4'h0, reg_wdata[3:0]};
        // request only sticks while suspended
        ctrl_reg[`UEP_CTRL_RESUME] <= reg_wdata[`UEP_CTRL_RESUME]
          & status_reg[`UEP_ST_SUSPEND];
      end
      if (idle_cnt_reg == 24'(SUSPEND_CYC - 1)) begin
        ctrl_reg[`UEP_CTRL_LOWSPEED] <= 1'b0;
      end
      if (rs_state_reg == UEP_RS_DRIVE && rs_cnt_reg == 24'h000000) begin
        ctrl_reg[`UEP_CTRL_RESUME] <= 1'b0;
      end
    end
  end

  // event flags; hardware set wins over software clear (write 1 to clear)
  always_ff @(posedge clk) begin
    logic set_susp, set_wake;
    set_susp = idle_cnt_reg == 24'(SUSPEND_CYC - 1);
    set_wake = !line_idle && !line_se0;
    if (!reset_n) begin
      status_reg <= 5'h00;
    end else begin
      if (wr_status) begin
        status_reg <= status_reg & ~reg_wdata[4:0];
      end
      if (set_susp) begin
        status_reg[`UEP_ST_SUSPEND] <= 1'b1;
        status_reg[`UEP_ST_WAKE] <= 1'b0;
      end
      if (set_wake) begin
        status_reg[`UEP_ST_WAKE] <= 1'b1;
        status_reg[`UEP_ST_SUSPEND] <= 1'b0;
      end
      if (rs_state_reg == UEP_RS_WAIT && idle_cnt_reg >= 24'(RESUME_WAIT_CYC)) begin
        status_reg[`UEP_ST_UPRESUME] <= 1'b1;
        status_reg[`UEP_ST_SUSPEND] <= 1'b0;
      end
      if (line_eor) begin
        status_reg[`UEP_ST_EORESUME] <= 1'b1;
      end
      if (bus_reset) begin
        status_reg[`UEP_ST_BUSRESET] <= 1'b1;
      end
    end
  end

  // upstream resume sequencer
  always_ff @(posedge clk) begin
    if (!reset_n || ctl_off) begin
      rs_state_reg <= UEP_RS_IDLE;
      rs_cnt_reg <= 24'h000000;
    end else begin
      case (rs_state_reg)
        UEP_RS_IDLE: begin
          if (ctrl_reg[`UEP_CTRL_RESUME]) begin
            rs_state_reg <= UEP_RS_WAIT;
          end
        end
        UEP_RS_WAIT: begin
          if (idle_cnt_reg >= 24'(RESUME_WAIT_CYC)) begin
            rs_state_reg <= UEP_RS_DRIVE;
            rs_cnt_reg <= 24'(RESUME_DRIVE_CYC - 1);
          end
        end
        UEP_RS_DRIVE: begin
          if (rs_cnt_reg == 24'h000000) begin
            rs_state_reg <= UEP_RS_IDLE;
          end else begin
            rs_cnt_reg <= rs_cnt_reg - 24'h000001;
          end
        end
        default: rs_state_reg <= UEP_RS_IDLE;
      endcase
    end
  end

  // device address and its enable
  always_ff @(posedge clk) begin
    if (!reset_n || bus_reset) begin
      dev_addr_reg <= `UEP_DEFAULT_ADDR;
      addr_en_reg <= 1'b0;
    end else if (ctl_off) begin
      addr_en_reg <= 1'b0;
    end else if (wr_addr) begin
      dev_addr_reg <= reg_wdata[6:0];
      addr_en_reg <= reg_wdata[`UEP_ADDR_ENABLE];
    end
  end

  // endpoint selection steers every endpoint register access
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ep_sel_reg <= 3'h0;
    end else if (wr_sel) begin
      ep_sel_reg <= reg_wdata[2:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EP; gi++) begin : g_ep
      logic sel, hit, setup_in, stall_out;
      assign sel = ep_sel_reg == 3'(gi);
      assign hit = pkt.valid && pkt.ep == 3'(gi) && ans_match;
      assign setup_in = hit && pkt.tok == UEP_TOK_SETUP && ep_cfg_reg[gi][`UEP_CFG_CONTROL]
        && ep_flag_reg[gi][`UEP_FL_CONFIGURATION_VALID_FLAG];
      assign stall_out = hit && !setup_in && stall_rq_reg[gi] && !pkt.retry
        && ep_flag_reg[gi][`UEP_FL_CONFIGURATION_VALID_FLAG];

      // configuration survives disable; memory stays reserved
      always_ff @(posedge clk) begin
        if (!reset_n || (bus_reset && gi != 0)) begin
          ep_cfg_reg[gi] <= 8'h00;
        end else if (bus_reset) begin
          ep_cfg_reg[gi][`UEP_CFG_ENABLE] <= 1'b0;
        end else if (wr_cfg && sel) begin
          ep_cfg_reg[gi] <= reg_wdata;
        end
      end

      always_ff @(posedge clk) begin
        logic size_ok;
        size_ok = (32'd8 << reg_wdata[3:1]) * (reg_wdata[`UEP_CFG_BANK] ? 32'd2 : 32'd1)
          <= 32'(MEM_BYTES);
        if (!reset_n || ctl_off || !ep_cfg_reg[gi][`UEP_CFG_ENABLE]) begin
          stall_rq_reg[gi] <= 1'b0;
          ep_flag_reg[gi] <= 8'h00;
          if (wr_cfg && sel && reset_n && !ctl_off) begin
            ep_flag_reg[gi][`UEP_FL_CONFIGURATION_VALID_FLAG] <= reg_wdata[`UEP_CFG_ENABLE] && size_ok;
          end
        end else begin
          if (wr_cfg && sel) begin
            ep_flag_reg[gi][`UEP_FL_CONFIGURATION_VALID_FLAG] <= reg_wdata[`UEP_CFG_ENABLE] && size_ok;
          end
          if (wr_flag && sel) begin
            ep_flag_reg[gi][5:0] <= ep_flag_reg[gi][5:0] & reg_wdata[5:0];
          end
          if (wr_cmd && sel && reg_wdata[`UEP_CMD_STALL_SET]) begin
            stall_rq_reg[gi] <= 1'b1;
          end
          if (wr_cmd && sel && reg_wdata[`UEP_CMD_STALL_CLR]) begin
            stall_rq_reg[gi] <= 1'b0;
          end
          if (wr_cmd && sel && reg_wdata[`UEP_CMD_RESET_TOGGLE]) begin
            ep_flag_reg[gi][`UEP_FL_TOGGLE] <= 1'b0;
          end
          if (setup_in) begin
            stall_rq_reg[gi] <= 1'b0;
            ep_flag_reg[gi][6:0] <= ep_flag_reg[gi][6:0] & 7'h40;
            ep_flag_reg[gi][`UEP_FL_SETUP] <= 1'b1;
            ep_flag_reg[gi][`UEP_FL_TOGGLE] <= 1'b1;
          end else if (stall_out) begin
            ep_flag_reg[gi][`UEP_FL_STALLED] <= 1'b1;
          end else if (hit && ep_flag_reg[gi][`UEP_FL_CONFIGURATION_VALID_FLAG] && !pkt.retry
            && !stall_rq_reg[gi]) begin
            // a NAKed or stalled packet is dropped and raises no data flags
            ep_flag_reg[gi][`UEP_FL_TOGGLE] <= ~ep_flag_reg[gi][`UEP_FL_TOGGLE];
            if (pkt.tok == UEP_TOK_OUT) begin
              ep_flag_reg[gi][`UEP_FL_OUT] <= 1'b1;
              if (!ep_cfg_reg[gi][`UEP_CFG_CONTROL]) begin
                ep_flag_reg[gi][`UEP_FL_RWOK] <= 1'b1;
                ep_flag_reg[gi][`UEP_FL_FIFOCTL] <= 1'b1;
              end
            end else begin
              ep_flag_reg[gi][`UEP_FL_INREADY] <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // only the stored address once enabled, else only the default one
  assign ans_match = addr_en_reg ? (pkt.addr == dev_addr_reg)
    : (pkt.addr == `UEP_DEFAULT_ADDR);

  // handshake selection for the addressed endpoint
  always_ff @(posedge clk) begin
    logic [2:0] e;
    e = pkt.ep;
    if (!reset_n || ctl_off) begin
      ans <= '0;
    end else if (pkt.valid && ans_match && 32'(e) < NUM_EP) begin
      ans.valid <= 1'b1;
      if (!ep_cfg_reg[e][`UEP_CFG_ENABLE] || !ep_flag_reg[e][`UEP_FL_CONFIGURATION_VALID_FLAG]) begin
        ans.valid <= 1'b0;
        ans.hs <= UEP_HS_NONE;
      end else if (pkt.tok == UEP_TOK_SETUP && ep_cfg_reg[e][`UEP_CFG_CONTROL]) begin
        ans.hs <= UEP_HS_ACK;
      end else if (pkt.retry) begin
        // retry checked ahead of stall so a busy endpoint never stalls by mistake
        ans.hs <= UEP_HS_NAK;
      end else if (stall_rq_reg[e]) begin
        ans.hs <= UEP_HS_STALL;
      end else begin
        ans.hs <= UEP_HS_ACK;
      end
    end else begin
      ans <= '0;
    end
  end

  // pins: pull-up by speed, gated by detach and enable
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pullup_dp <= 1'b0;
      pullup_dm <= 1'b0;
      full_speed <= 1'b1;
      resume_drive <= 1'b0;
    end else begin
      // pull-ups follow the control register one cycle later
      pullup_dp <= !ctl_off && !ctrl_reg[`UEP_CTRL_DETACH]
        && !ctrl_reg[`UEP_CTRL_LOWSPEED];
      pullup_dm <= !ctl_off && !ctrl_reg[`UEP_CTRL_DETACH]
        && ctrl_reg[`UEP_CTRL_LOWSPEED];
      full_speed <= !ctrl_reg[`UEP_CTRL_LOWSPEED];
      resume_drive <= rs_state_reg == UEP_RS_DRIVE;
    end
  end

  // read mux; stall-clear never reads set, control fifo/rw read 0
  always_comb begin
    rdata_next = 8'h00;
    case (reg_addr)
      `UEP_REG_CTRL: rdata_next = ctrl_reg;
      `UEP_REG_STATUS: rdata_next = {3'h0, status_reg};
      `UEP_REG_ADDR: rdata_next = {addr_en_reg, dev_addr_reg};
      `UEP_REG_EPSEL: rdata_next = {5'h00, ep_sel_reg};
      `UEP_REG_EPCFG: rdata_next = (32'(ep_sel_reg) < NUM_EP) ? ep_cfg_reg[ep_sel_reg] : 8'h00;
      `UEP_REG_EPCMD: rdata_next = (32'(ep_sel_reg) < NUM_EP)
        ? {7'h00, stall_rq_reg[ep_sel_reg]} : 8'h00;
      `UEP_REG_EPFLAG: begin
        if (32'(ep_sel_reg) < NUM_EP) begin
          rdata_next = ep_flag_reg[ep_sel_reg];
          if (ep_cfg_reg[ep_sel_reg][`UEP_CFG_CONTROL]) begin
            rdata_next[`UEP_FL_FIFOCTL] = 1'b0;
            rdata_next[`UEP_FL_RWOK] = 1'b0;
          end
        end
      end
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rdata_next : 8'h00;
    end
  end
endmodule : uep_ctrl
`default_nettype wire

// ===== design/uep_pkg.sv
// types for the usb endpoint control block
// assumes uep_consts.svh supplies numeric constants
`default_nettype none
package uep_pkg;
  typedef enum logic [1:0] {
    UEP_TOK_OUT = 2'b00,
    UEP_TOK_IN = 2'b01,
    UEP_TOK_SETUP = 2'b10
  } uep_tok_e;
  typedef enum logic [1:0] {
    UEP_HS_NONE = 2'b00,
    UEP_HS_ACK = 2'b01,
    UEP_HS_NAK = 2'b10,
    UEP_HS_STALL = 2'b11
  } uep_hs_e;
  typedef enum logic [1:0] {
    UEP_RS_IDLE = 2'b00,
    UEP_RS_WAIT = 2'b01,
    UEP_RS_DRIVE = 2'b10
  } uep_rs_e;
  typedef struct packed {
    logic valid;
    uep_tok_e tok;
    logic [6:0] addr;
    logic [2:0] ep;
    logic retry;
  } uep_pkt_s;
  typedef struct packed {
    logic valid;
    uep_hs_e hs;
  } uep_ans_s;
endpackage : uep_pkg
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for uep_ctrl: register tasks, host model, random endpoint configs
// assumes shortened suspend/resume counts and the default endpoint memory size
`default_nettype none
`include "uep_consts.svh"
module tb_top
  import uep_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
  logic clk = 1'b0, reset_n, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v, c;
  logic [6:0] da;
  logic line_idle, line_se0, line_eor, resume_drive, pullup_dp, pullup_dm, full_speed;
  uep_pkt_s pkt;
  uep_ans_s ans, got;
  int error_cnt = 0, num_checks = 0, seed = 32'h3573d5fa, i, n;
  logic [7:0] corner [3] = '{8'h0f, 8'h1d, 8'h0d};
  always #20 clk = ~clk;
  uep_ctrl #(.SUSPEND_CYC(50), .RESUME_WAIT_CYC(80), .RESUME_DRIVE_CYC(20)) i_dut (
    .clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .line_idle,
    .line_se0, .line_eor, .pkt, .ans, .resume_drive, .pullup_dp, .pullup_dm, .full_speed);
  uep_host_model i_host (.clk, .line_idle, .line_se0, .line_eor, .pkt, .ans);
  function automatic logic cfg_ok(input logic [7:0] cf);
    return cf[0] && ((32'd8 << cf[3:1]) * (cf[4] ? 2 : 1) <= 832);
  endfunction
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rdchk(input string nm, input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata & m;
    `CHK(nm, e, v)
  endtask
  task akchk(input string nm, input uep_tok_e t, input logic [6:0] a, input logic [2:0] e,
             input logic r, input logic vv, input uep_hs_e h);
    i_host.send(t, a, e, r, got);
    `CHK(nm, vv, got.valid)
    if (vv) `CHK(nm, h, got.hs)
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // bounded wait on the resume drive level; running out ends the run
  task wait_drive(input logic lv);
    for (n = 0; n < 300 && resume_drive !== lv; n++) begin
      @(posedge clk);
      #1;
    end
    if (resume_drive !== lv) begin
      error_cnt++;
      $display("ERROR resume_drive wait expired");
      finish_test();
    end
  endtask
  initial begin
    reset_n <= 1'b0;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= 4'h0;
    reg_wdata <= 8'h00;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rdchk("ctrl", `UEP_REG_CTRL, 8'hff, `UEP_CTRL_RESET);
    `CHK("pullups", 2'b00, {pullup_dp, pullup_dm})
    rdchk("addr", `UEP_REG_ADDR, 8'hff, 8'h00);
    wr(`UEP_REG_CTRL, 8'h01);
    @(posedge clk);
    #1 `CHK("dp", 2'b10, {pullup_dp, pullup_dm})
    wr(`UEP_REG_CTRL, 8'h05);
    @(posedge clk);
    #1 `CHK("dm", 2'b01, {pullup_dp, pullup_dm})
    wr(`UEP_REG_CTRL, 8'h01);
    $display("test attach done");
    wr(`UEP_REG_EPSEL, 8'h00);
    wr(`UEP_REG_EPCFG, 8'h47);
    rdchk("cfg0", `UEP_REG_EPFLAG, 8'h40, 8'h40);
    wr(`UEP_REG_EPSEL, 8'h01);
    wr(`UEP_REG_EPCFG, 8'h01);
    akchk("out1", UEP_TOK_OUT, 7'h00, 3'h1, 1'b0, 1'b1, UEP_HS_ACK);
    wr(`UEP_REG_EPFLAG, 8'h00);
    wr(`UEP_REG_EPCMD, 8'h01);
    akchk("st_out", UEP_TOK_OUT, 7'h00, 3'h1, 1'b0, 1'b1, UEP_HS_STALL);
    akchk("st_in", UEP_TOK_IN, 7'h00, 3'h1, 1'b0, 1'b1, UEP_HS_STALL);
    akchk("retry", UEP_TOK_OUT, 7'h00, 3'h1, 1'b1, 1'b1, UEP_HS_NAK);
    rdchk("stfl", `UEP_REG_EPFLAG, 8'h26, 8'h04);
    wr(`UEP_REG_EPCMD, 8'h02);
    rdchk("stclr", `UEP_REG_EPCMD, 8'h03, 8'h00);
    akchk("unst", UEP_TOK_OUT, 7'h00, 3'h1, 1'b0, 1'b1, UEP_HS_ACK);
    $display("test stall done");
    wr(`UEP_REG_EPSEL, 8'h00);
    wr(`UEP_REG_EPCMD, 8'h01);
    akchk("c_st", UEP_TOK_OUT, 7'h00, 3'h0, 1'b0, 1'b1, UEP_HS_STALL);
    akchk("setup", UEP_TOK_SETUP, 7'h00, 3'h0, 1'b0, 1'b1, UEP_HS_ACK);
    rdchk("su_cmd", `UEP_REG_EPCMD, 8'h01, 8'h00);
    rdchk("su_fl", `UEP_REG_EPFLAG, 8'h37, 8'h01);
    akchk("c_out", UEP_TOK_OUT, 7'h00, 3'h0, 1'b0, 1'b1, UEP_HS_ACK);
    rdchk("c_fl", `UEP_REG_EPFLAG, 8'h32, 8'h02);
    $display("test control done");
    wr(`UEP_REG_EPSEL, 8'h01);
    wr(`UEP_REG_EPCFG, 8'h3b);
    akchk("en_pkt", UEP_TOK_OUT, 7'h00, 3'h1, 1'b0, 1'b1, UEP_HS_ACK);
    wr(`UEP_REG_EPCFG, 8'h3a);
    rdchk("keep", `UEP_REG_EPCFG, 8'h3e, 8'h3a);
    rdchk("dis_fl", `UEP_REG_EPFLAG, 8'hc0, 8'h00);
    akchk("dis_pkt", UEP_TOK_OUT, 7'h00, 3'h1, 1'b0, 1'b0, UEP_HS_ACK);
    wr(`UEP_REG_EPSEL, 8'h02);
    for (i = 0; i < 10; i++) begin
      c = (i < 3) ? corner[i] : (8'($random(seed)) & 8'h3f);
      wr(`UEP_REG_EPCFG, c);
      rdchk("rcfg", `UEP_REG_EPFLAG, 8'h40, {1'b0, cfg_ok(c), 6'h00});
      n = $random(seed);
      akchk("rpkt", n[0] ? UEP_TOK_IN : UEP_TOK_OUT, 7'h00, 3'h2, n[1], cfg_ok(c),
            n[1] ? UEP_HS_NAK : UEP_HS_ACK);
    end
    $display("test endpoint config done");
    // random address with bit 0 forced so it never equals the default 7'h00
    da = 7'($random(seed)) | 7'h01;
    wr(`UEP_REG_ADDR, {1'b0, da});
    akchk("zlp", UEP_TOK_IN, 7'h00, 3'h0, 1'b0, 1'b1, UEP_HS_ACK);
    akchk("early", UEP_TOK_OUT, da, 3'h0, 1'b0, 1'b0, UEP_HS_ACK);
    wr(`UEP_REG_ADDR, {1'b1, da});
    akchk("new", UEP_TOK_OUT, da, 3'h0, 1'b0, 1'b1, UEP_HS_ACK);
    akchk("no_ep", UEP_TOK_OUT, da, 3'h7, 1'b0, 1'b0, UEP_HS_ACK);
    akchk("old", UEP_TOK_OUT, 7'h00, 3'h0, 1'b0, 1'b0, UEP_HS_ACK);
    wr(`UEP_REG_CTRL, 8'h00);
    wr(`UEP_REG_CTRL, 8'h01);
    rdchk("off_aen", `UEP_REG_ADDR, 8'hff, {1'b0, da});
    wr(`UEP_REG_ADDR, {1'b1, da});
    i_host.se0(60);
    rdchk("short", `UEP_REG_ADDR, 8'hff, {1'b1, da});
    i_host.se0(66);
    rdchk("br_addr", `UEP_REG_ADDR, 8'hff, 8'h00);
    rdchk("br_st", `UEP_REG_STATUS, 8'h10, 8'h10);
    $display("test address done");
    wr(`UEP_REG_CTRL, 8'h05);
    wr(`UEP_REG_STATUS, 8'h1f);
    i_host.set_idle(1'b1);
    repeat (60) @(posedge clk);
    rdchk("susp", `UEP_REG_STATUS, 8'h03, 8'h01);
    `CHK("fs", 1'b1, full_speed)
    i_host.set_idle(1'b0);
    repeat (2) @(posedge clk);
    rdchk("wake", `UEP_REG_STATUS, 8'h03, 8'h02);
    wr(`UEP_REG_CTRL, 8'h09);
    rdchk("rq_ign", `UEP_REG_CTRL, 8'h08, 8'h00);
    wr(`UEP_REG_STATUS, 8'h1f);
    i_host.set_idle(1'b1);
    repeat (60) @(posedge clk);
    wr(`UEP_REG_CTRL, 8'h09);
    wait_drive(1'b1);
    rdchk("upres", `UEP_REG_STATUS, 8'h05, 8'h04);
    wait_drive(1'b0);
    rdchk("rq_end", `UEP_REG_CTRL, 8'h08, 8'h00);
    i_host.set_idle(1'b0);
    i_host.eor();
    rdchk("eor", `UEP_REG_STATUS, 8'h08, 8'h08);
    $display("test suspend and resume done");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire

// ===== dv/uep_host_model.sv
// behavioural usb host: token events, bus idle/active, SE0 and end-of-resume
// assumes the bench calls its tasks and the decoder view of the line
`default_nettype none
module uep_host_model
  import uep_pkg::*;
(
  input wire logic clk,
  output logic line_idle,
  output logic line_se0,
  output logic line_eor,
  output uep_pkt_s pkt,
  input wire uep_ans_s ans
);
  timeunit 1ns;
  timeprecision 1ps;
  logic quiet;
  initial begin
    quiet = 1'b0;
    line_se0 = 1'b0;
    line_eor = 1'b0;
    pkt = '0;
  end
  assign line_idle = quiet && !line_se0;
  task set_idle(input logic q);
    quiet <= q;
  endtask
  // released token fields flip so a stale value is never mistaken for a live one
  task send(input uep_tok_e t, input logic [6:0] a, input logic [2:0] e, input logic r,
            output uep_ans_s got);
    @(posedge clk);
    pkt <= '{1'b1, t, a, e, r};
    @(posedge clk);
    pkt <= {1'b0, ~pkt[12:0]};
    #1;
    got = ans;
  endtask
  task se0(input int n);
    line_se0 <= 1'b1;
    repeat (n) @(posedge clk);
    line_se0 <= 1'b0;
  endtask
  task eor;
    line_eor <= 1'b1;
    @(posedge clk);
    line_eor <= 1'b0;
  endtask
endmodule // uep_host_model
`default_nettype wire

// ===== dv/uep_props.sv
// port-level assertions for uep_ctrl, bound into every instance
// assumes the top module's ports and the same shortened timing parameters
`default_nettype none
`include "uep_consts.svh"
module uep_props
  import uep_pkg::*;
#(
  parameter int SUSPEND_CYC = 50,
  parameter int RESUME_WAIT_CYC = 80
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic line_idle,
  input wire logic line_se0,
  input wire logic line_eor,
  input wire uep_pkt_s pkt,
  input wire uep_ans_s ans,
  input wire logic resume_drive,
  input wire logic pullup_dp,
  input wire logic pullup_dm,
  input wire logic full_speed
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  int idle_cnt;
  // saturates so a long quiet spell cannot wrap
  always_ff @(posedge clk) begin
    if (!reset_n || !line_idle) begin
      idle_cnt <= 0;
    end else if (idle_cnt < 100000) begin
      idle_cnt <= idle_cnt + 1;
    end
  end
  sequence retry_pkt;
    pkt.valid && pkt.retry && pkt.tok != UEP_TOK_SETUP;
  endsequence
  sequence stall_ans;
    ans.valid && ans.hs == UEP_HS_STALL;
  endsequence
  sequence resume_start;
    $rose(resume_drive);
  endsequence
  ans_cause_a:
    assert property (ans.valid |-> $past(pkt.valid)) else $error("answer without a packet");
  retry_wins_a:
    assert property (retry_pkt |=> not stall_ans) else $error("stall sent despite retry");
  suspend_fs_a:
    assert property (idle_cnt == SUSPEND_CYC + 3 |-> full_speed)
    else $error("no full speed after idle");
  pullup_excl_a:
    assert property (!(pullup_dp && pullup_dm)) else $error("both pull-ups on");
  detach_rst_a:
    assert property ($rose(reset_n) |-> !pullup_dp && !pullup_dm)
    else $error("pull-up on after reset");
  resume_idle_a:
    assert property (resume_start |-> idle_cnt >= RESUME_WAIT_CYC)
    else $error("resume driven too early");
  resume_hold_a:
    assert property (resume_start |=> resume_drive [*8]) else $error("resume drive cut short");
  clr_read0_a:
    assert property (reg_rd && reg_addr == `UEP_REG_EPCMD |=> !reg_rdata[`UEP_CMD_STALL_CLR])
    else $error("stall clear read as one");
endmodule // uep_props
bind uep_ctrl uep_props #(.SUSPEND_CYC(SUSPEND_CYC), .RESUME_WAIT_CYC(RESUME_WAIT_CYC)) i_props (
  .clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .line_idle, .line_se0,
  .line_eor, .pkt, .ans, .resume_drive, .pullup_dp, .pullup_dm, .full_speed);
`default_nettype wire
